/* File: core/cocc_channel.v */
// one output channel: format, coarse phase, divider, source select, sync
// assumes sys_clk ticks once per half period of the divider input clock,
// and that every input is synchronous to sys_clk
`timescale 1ns/1ns
`include "cocc_defs.vh"
`default_nettype none

module cocc_channel
(
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // register port
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [11:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // clock sources
  input  wire        pll1_in,
  input  wire        sysref_in,
  // channel outputs
  output reg         ch_out,
  output reg         fmt_lvds,
  output reg         fmt_boost,
  output reg         fmt_hstl,
  output reg         sync_pulse
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg  [7:0] channel_format_and_phase;   // format and coarse delay
  reg  [7:0] channel_control;            // source select in top bits
  reg  [7:0] channel_divide_ratio;       // divide minus one
  reg  [7:0] distribution_sync_trigger;  // bit 0 only is live

  wire       wr_sync  = reg_wr && (reg_addr == `COCC_ADDR_SYNC);
  // falling transition of the stored sync bit, caused by this write
  wire       sync_evt = wr_sync && distribution_sync_trigger[`COCC_SYNC_BIT]
                        && !reg_wdata[`COCC_SYNC_BIT];

  // register writes
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      channel_format_and_phase  <= `COCC_RST_FMT_PHASE;
      channel_control           <= `COCC_RST_CTRL;
      channel_divide_ratio      <= `COCC_RST_DIVIDE;
      distribution_sync_trigger <= `COCC_RST_SYNC;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `COCC_ADDR_FMT_PHASE: channel_format_and_phase <= reg_wdata;
        `COCC_ADDR_CTRL:      channel_control          <= reg_wdata;
        `COCC_ADDR_DIVIDE:    channel_divide_ratio     <= reg_wdata;
        // reserved bits hold zero
        `COCC_ADDR_SYNC:
          distribution_sync_trigger <= {7'h00, reg_wdata[`COCC_SYNC_BIT]};
        default:              ;  // unmapped writes are dropped
      endcase
    end
  end

  // read data, registered; unmapped reads give zero
  always @(posedge sys_clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `COCC_ADDR_FMT_PHASE: reg_rdata <= channel_format_and_phase;
        `COCC_ADDR_CTRL:      reg_rdata <= channel_control;
        `COCC_ADDR_DIVIDE:    reg_rdata <= channel_divide_ratio;
        `COCC_ADDR_SYNC:      reg_rdata <= distribution_sync_trigger;
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // output format decode
  // ----------------------------------------------------------------------
  wire [1:0] fmt = channel_format_and_phase[`COCC_FMT_HI:`COCC_FMT_LO];

  // upper bit set means HSTL whatever the lower bit says
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      fmt_lvds  <= 1'b1;
      fmt_boost <= 1'b0;
      fmt_hstl  <= 1'b0;
    end
    else
    begin
      fmt_hstl  <= fmt[1];
      // plain lvds only for code 00, so the three levels stay one-hot
      fmt_lvds  <= !fmt[1] && !fmt[0];
      fmt_boost <= !fmt[1] && fmt[0];
    end
  end

  // ----------------------------------------------------------------------
  // divider with coarse delay
  // ----------------------------------------------------------------------
  localparam ST_DELAY = 1'b0;  // holding low for the coarse delay
  localparam ST_RUN   = 1'b1;  // free running divider

  reg        state;
  reg  [5:0] dly_cnt;          // half periods still to wait
  reg  [7:0] half_cnt;         // half periods in current level
  reg        div_out;          // divided clock
  reg        next_state;

  wire [5:0] dly = channel_format_and_phase[`COCC_DLY_HI:`COCC_DLY_LO];

  // state choice; sync restarts the delay so channels realign
  always @*
  begin
    next_state = state;
    case (state)
      ST_DELAY: if (dly_cnt == 6'h00) next_state = ST_RUN;
      ST_RUN:   next_state = ST_RUN;
      default:  next_state = ST_DELAY;
    endcase
    if (sync_evt)
      next_state = ST_DELAY;
  end

  // each level lasts ratio+1 half periods, so a full cycle is ratio+1
  // input periods; every ratio stays at fifty percent duty for free
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      state    <= ST_DELAY;
      dly_cnt  <= 6'h00;
      half_cnt <= 8'h00;
      div_out  <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (sync_evt)
      begin
        dly_cnt  <= dly;
        half_cnt <= 8'h00;
        div_out  <= 1'b0;
      end
      else if (state == ST_DELAY)
      begin
        if (dly_cnt != 6'h00)
          dly_cnt <= dly_cnt - 6'h01;
      end
      else if (half_cnt == channel_divide_ratio)
      begin
        half_cnt <= 8'h00;
        div_out  <= !div_out;
      end
      else
        half_cnt <= half_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // source select and sysref retiming
  // ----------------------------------------------------------------------
  reg        div_q;            // last divider level, for edge detect
  reg        pll1_q;           // last pll1 level, for edge detect
  reg        sysref_div;       // sysref taken on divider rising edge
  reg        sysref_pll1;      // sysref taken on pll1 chosen edge
  wire [2:0] src = channel_control[`COCC_SRC_HI:`COCC_SRC_LO];
  // inverted pll1 retiming samples on the falling edge instead
  wire       pll1_edge = src[2] ? (pll1_q && !pll1_in) : (!pll1_q && pll1_in);

  // retiming flops
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      div_q       <= 1'b0;
      pll1_q      <= 1'b0;
      sysref_div  <= 1'b0;
      sysref_pll1 <= 1'b0;
    end
    else
    begin
      div_q  <= div_out;
      pll1_q <= pll1_in;
      if (div_out && !div_q)
        sysref_div <= sysref_in;
      if (pll1_edge)
        sysref_pll1 <= sysref_in;
    end
  end

  // output mux, registered
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      ch_out     <= 1'b0;
      sync_pulse <= 1'b0;
    end
    else
    begin
      sync_pulse <= sync_evt;
      case (src[1:0])
        2'h0:    ch_out <= div_out;
        2'h1:    ch_out <= src[2] ? !pll1_in : pll1_in;
        2'h2:    ch_out <= sysref_div;
        2'h3:    ch_out <= sysref_pll1;
        default: ch_out <= 1'b0;
      endcase
    end
  end

endmodule // cocc_channel

`default_nettype wire

/* File: core/cocc_defs.vh */
// constants for the clock output channel configuration block
// assumes one byte-wide register port and sys_clk running at twice the divider input rate
`ifndef COCC_DEFS_VH
`define COCC_DEFS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define COCC_ADDR_SYNC        12'h32A
`define COCC_ADDR_FMT_PHASE   12'h300
`define COCC_ADDR_CTRL        12'h301
`define COCC_ADDR_DIVIDE      12'h302

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define COCC_FMT_HI           7
`define COCC_FMT_LO           6
`define COCC_DLY_HI           5
`define COCC_DLY_LO           0
`define COCC_SRC_HI           7
`define COCC_SRC_LO           5
`define COCC_SYNC_BIT         0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define COCC_RST_FMT_PHASE    8'h00
`define COCC_RST_CTRL         8'h00
`define COCC_RST_DIVIDE       8'h00
`define COCC_RST_SYNC         8'h00

`endif

/* File: bench/cocc_channel_chk.sv */
// checker for cocc_channel port relations
// assumes it is bound onto the cocc_channel instance
`timescale 1ns/1ns
`include "cocc_defs.vh"
`default_nettype none
module cocc_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        pll1_in,
  input wire logic        ch_out,
  input wire logic        fmt_lvds,
  input wire logic        fmt_boost,
  input wire logic        fmt_hstl,
  input wire logic        sync_pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // format write and sync clear write decodes
  wire fw = reg_wr && reg_addr == `COCC_ADDR_FMT_PHASE;
  wire s0 = reg_wr && reg_addr == `COCC_ADDR_SYNC && !reg_wdata[0];
  // shadow of the source field, tracked from the write strobes
  logic [2:0] src_q;
  always @(posedge sys_clk)
  begin
    if (rst)
      src_q <= 3'h0;
    else if (reg_wr && reg_addr == `COCC_ADDR_CTRL)
      src_q <= reg_wdata[`COCC_SRC_HI:`COCC_SRC_LO];
  end
  chk_fmt_onehot: assert property ($onehot({fmt_lvds, fmt_boost, fmt_hstl}))
    else $error("format outputs not one-hot");
  chk_fmt_hstl: assert property (fw && reg_wdata[7] |-> ##[1:2] fmt_hstl)
    else $error("hstl not selected");
  chk_fmt_boost: assert property (fw && reg_wdata[7:6] == 2'b01 |-> ##[1:2] fmt_boost)
    else $error("boost not selected");
  chk_sync_cause: assert property (sync_pulse |-> $past(s0) || $past(s0, 2))
    else $error("sync pulse without clearing write");
  chk_sync_short: assert property (sync_pulse |=> !sync_pulse)
    else $error("sync pulse too long");
  chk_sync_rsvd: assert property (reg_rd && reg_addr == `COCC_ADDR_SYNC |=> reg_rdata[7:1] == 7'h00)
    else $error("sync reserved bits read nonzero");
  cover property (sync_pulse);
  cover property (fw && reg_wdata[7]);
  chk_src_pll1: assert property ($past(src_q[1:0]) == 2'b01 |-> ch_out == ($past(pll1_in) ^ $past(src_q[2])))
    else $error("pll1 source not passed to output");
  cover property ($rose(ch_out));
  cover property ($past(src_q) == 3'b011 && ch_out);
endmodule // cocc_chk
bind cocc_channel cocc_chk u_chk (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .pll1_in(pll1_in), .ch_out(ch_out), .fmt_lvds(fmt_lvds), .fmt_boost(fmt_boost),
  .fmt_hstl(fmt_hstl),
  .sync_pulse(sync_pulse));
`default_nettype wire

/* File: bench/cocc_channel_tb_top.sv */
// self-checking bench for cocc_channel
// assumes sys_clk at 100 ns; source inputs driven by the source scenario
`timescale 1ns/1ns
`include "cocc_defs.vh"
`default_nettype none
module cocc_channel_tb_top;
  logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [11:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0;
  logic pll1_in = 0, sysref_in = 0;
  wire [7:0] reg_rdata;
  wire ch_out, fmt_lvds, fmt_boost, fmt_hstl, sync_pulse;
  int err_total = 0, check_count = 0;
  int t0, h0, t1, h1;
  cocc_channel uut (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pll1_in(pll1_in),
    .sysref_in(sysref_in), .ch_out(ch_out), .fmt_lvds(fmt_lvds), .fmt_boost(fmt_boost),
    .fmt_hstl(fmt_hstl), .sync_pulse(sync_pulse));
  initial forever #50 sys_clk = ~sys_clk;
  task automatic chk(string n, logic [8:0] e, logic [8:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %0h got %0h", n, e, g);
    end
  endtask
  // one write or read strobe, driven on falling edges
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(negedge sys_clk); reg_wr = 1; reg_addr = a; reg_wdata = d;
    @(negedge sys_clk); reg_wr = 0;
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e);
    @(negedge sys_clk); reg_rd = 1; reg_addr = a;
    @(negedge sys_clk); reg_rd = 0;
    chk("rdata", {1'b0, e}, {1'b0, reg_rdata});
  endtask
  // program ratio and delay, sync, time first rise and high length
  task automatic run(logic [7:0] r, logic [5:0] d, output int t, output int h);
    wr(`COCC_ADDR_DIVIDE, r);
    wr(`COCC_ADDR_FMT_PHASE, {2'b00, d});
    wr(`COCC_ADDR_SYNC, 8'h01);
    wr(`COCC_ADDR_SYNC, 8'h00);
    t = 0; h = 0;
    while (sync_pulse !== 1'b1 && t < 8) begin @(negedge sys_clk); t++; end
    chk("sync_pulse", 1, sync_pulse);
    t = 0;
    while (ch_out === 1'b1 && t < 600) begin @(negedge sys_clk); t++; end
    while (ch_out !== 1'b1 && t < 600) begin @(negedge sys_clk); t++; end
    while (ch_out === 1'b1 && h < 600) begin @(negedge sys_clk); h++; end
  endtask
  task automatic t_fmt;
    for (int c = 0; c < 4; c++)
    begin
      wr(`COCC_ADDR_FMT_PHASE, 8'(c << 6));
      @(negedge sys_clk);
      chk("fmt", {6'h00, c == 0, c == 1, c[1]}, {6'h00, fmt_lvds, fmt_boost, fmt_hstl});
      rd(`COCC_ADDR_FMT_PHASE, 8'(c << 6));
    end
  endtask
  task automatic t_sync;
    logic s;
    wr(`COCC_ADDR_SYNC, 8'h00);
    s = sync_pulse;
    repeat (2) begin @(negedge sys_clk); s |= sync_pulse; end
    chk("no_sync", 0, s);
    wr(`COCC_ADDR_SYNC, 8'hFF);
    rd(`COCC_ADDR_SYNC, 8'h01);
    wr(12'h0FF, 8'h5A);
    rd(12'h0FF, 8'h00);
  endtask
  // every source code family: pll1 straight and inverted, both retimings, alias of 000
  task automatic t_src;
    logic s;
    wr(`COCC_ADDR_CTRL, 8'h20);
    pll1_in = 1;
    @(negedge sys_clk);
    chk("src_pll1", 1, ch_out);
    wr(`COCC_ADDR_CTRL, 8'hA0);
    @(negedge sys_clk);
    chk("src_pll1_inv", 0, ch_out);
    rd(`COCC_ADDR_CTRL, 8'hA0);
    pll1_in = 0;
    wr(`COCC_ADDR_CTRL, 8'h60);
    sysref_in = 1;
    @(negedge sys_clk);
    chk("sysref_wait", 0, ch_out);
    pll1_in = 1;
    repeat (2) @(negedge sys_clk);
    chk("sysref_pll1", 1, ch_out);
    wr(`COCC_ADDR_CTRL, 8'hE0);
    sysref_in = 0;
    pll1_in = 0;
    repeat (2) @(negedge sys_clk);
    chk("sysref_pll1_inv", 0, ch_out);
    // divide by one, restarted by a sync so the old count cannot linger
    wr(`COCC_ADDR_DIVIDE, 8'h00);
    wr(`COCC_ADDR_SYNC, 8'h01);
    wr(`COCC_ADDR_SYNC, 8'h00);
    wr(`COCC_ADDR_CTRL, 8'h40);
    sysref_in = 1;
    repeat (4) @(negedge sys_clk);
    chk("sysref_div", 1, ch_out);
    sysref_in = 0;
    repeat (4) @(negedge sys_clk);
    chk("sysref_div_lo", 0, ch_out);
    wr(`COCC_ADDR_CTRL, 8'h80);
    @(negedge sys_clk);
    s = ch_out;
    @(negedge sys_clk);
    chk("src_div_alias", {8'h00, !s}, ch_out);
    rd(`COCC_ADDR_CTRL, 8'h80);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog, far beyond the fewer than one thousand cycles needed
  initial begin #2000000; err_total++; wrap_up; end
  initial
  begin
    repeat (5) @(negedge sys_clk);
    rst = 0;
    rd(`COCC_ADDR_FMT_PHASE, 8'h00);
    rd(`COCC_ADDR_DIVIDE, 8'h00);
    chk("lvds_rst", 1, fmt_lvds);
    t_fmt;
    t_sync;
    run(8'h03, 6'd0, t0, h0);
    chk("high_r3", 4, h0);
    run(8'h03, 6'd63, t1, h1);
    chk("delay63", 63, t1 - t0);
    run(8'hFF, 6'd0, t0, h0);
    chk("high_r255", 256, h0);
    t_src;
    wrap_up;
  end
endmodule // cocc_channel_tb_top
`default_nettype wire
